// file: include/irq_arbiter_pkg.sv
// Constants shared by the interrupt arbiter design files
package irq_arbiter_pkg;

  // ************************************
  // Sizes
  // ************************************
  localparam int SRC_NUM = 64;        // Interrupt sources
  localparam int NUM_W = 6;           // Vector number width
  localparam int LVL_NUM = 4;         // Priority levels 0..3
  localparam int ADDR_W = 24;         // Peripheral bus word address
  localparam int DATA_W = 16;         // Register width
  localparam int VEC_W = 32;          // Vector address width
  localparam int OFF_W = 5;           // Offset field of the address

  // ************************************
  // Register map
  // ************************************
  localparam logic [ADDR_W-1:0] BASE_ADDR = 24'h00f0e0;
  localparam logic [OFF_W-1:0] OFF_PRIO0 = 5'h00;
  localparam logic [OFF_W-1:0] OFF_PRIO6 = 5'h06;
  localparam logic [OFF_W-1:0] OFF_VBA = 5'h07;
  localparam logic [OFF_W-1:0] OFF_FM0 = 5'h08;
  localparam logic [OFF_W-1:0] OFF_FVL0 = 5'h09;
  localparam logic [OFF_W-1:0] OFF_FVH0 = 5'h0a;
  localparam logic [OFF_W-1:0] OFF_FM1 = 5'h0b;
  localparam logic [OFF_W-1:0] OFF_FVL1 = 5'h0c;
  localparam logic [OFF_W-1:0] OFF_FVH1 = 5'h0d;
  localparam logic [OFF_W-1:0] OFF_PEND0 = 5'h0e;
  localparam logic [OFF_W-1:0] OFF_PEND3 = 5'h11;
  localparam logic [OFF_W-1:0] OFF_CTRL = 5'h16;

  // ************************************
  // Field layouts and reset values
  // ************************************
  localparam int PRIO_REGS = 7;       // Priority registers 0..6
  localparam int FIXED_NUM = 9;       // Sources 0..8 have fixed level
  localparam int DBG_FIELDS = 7;      // Fields held in priority register 0
  localparam int FIELDS_PER_REG = 8;  // Fields in registers 1..6
  localparam logic [1:0] FIXED_LVL = 2'h3;
  localparam logic [1:0] FAST_LVL = 2'h2;
  localparam logic [DATA_W-1:0] PRIO0_WMASK = 16'hf3ff;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam int CTRL_CODE_LSB = 14;  // Presented level code
  localparam int CTRL_REQ_BIT = 13;   // Request presented
  localparam int CTRL_NUM_LSB = 7;    // Winning vector number
  localparam int CTRL_DIS_BIT = 5;    // Software disable of presentation

  // ************************************
  // Level codes to the core
  // ************************************
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_L0 = 2'h1;
  localparam logic [1:0] CODE_L1 = 2'h2;
  localparam logic [1:0] CODE_L23 = 2'h3;

  typedef enum {PH_BOOT, PH_RUN} phase_e;

endpackage

// file: core/irq_level_encoder.sv
// Lowest-number priority encoder for the requests of one level
`timescale 1ns/1ps
module irq_level_encoder
  import irq_arbiter_pkg::*;
#(
  parameter int WIDTH = SRC_NUM
) (
  // Requests of one level
  input wire logic [WIDTH-1:0] req,
  // Result
  output logic any,
  output logic [NUM_W-1:0] idx
);

  // ************************************
  // Encoder
  // ************************************
  // Scan downward so the lowest set bit is written last
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = NUM_W'(i);
      end
    end
  end

endmodule // irq_level_encoder

// file: core/irq_arbiter_unit.sv
// Interrupt arbiter: priorities, vector generation, fast match, wake
`timescale 1ns/1ps
module irq_arbiter_unit
  import irq_arbiter_pkg::*;
#(
  parameter logic [VEC_W-1:0] RESET_VEC = 32'h00000000,   // Initial fetch address
  parameter logic [DATA_W-1:0] VBA_RESET = 16'h0000       // Vector base after reset
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Interrupt sources
  input wire logic [SRC_NUM-1:0] irqIn,
  // Peripheral bus slave
  input wire logic busSel,
  input wire logic busWr,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busWdata,
  output logic [DATA_W-1:0] busRdata,
  // System integration unit
  input wire logic lowPower,
  output logic wakeReq,
  // Core side
  output logic coreIrq,
  output logic [1:0] coreLevel,
  output logic [VEC_W-1:0] coreVector,
  output logic coreFast,
  output logic bootDrive
);

  // ************************************
  // Functions
  // ************************************
  // Field code to {enable, level}; debug fields start at level 1
  function automatic logic [2:0] decodeField(input logic [1:0] code, input logic dbg);
    decodeField = {code != 2'h0, dbg ? code : code - 2'h1};
  endfunction

  // Level to code shown to the core
  function automatic logic [1:0] levelToCode(input logic [1:0] lvl);
    case (lvl)
      2'h0: levelToCode = CODE_L0;
      2'h1: levelToCode = CODE_L1;
      default: levelToCode = CODE_L23;
    endcase
  endfunction

  // ************************************
  // Registers
  // ************************************
  logic [DATA_W-1:0] prioReg_r [PRIO_REGS]; // Priority fields
  logic [DATA_W-1:0] vba_r;                  // Vector base
  logic [1:0][DATA_W-1:0] fastMatch_r;       // Fast match numbers
  logic [1:0][DATA_W-1:0] fastLow_r;         // Fast address low halves
  logic [1:0][DATA_W-1:0] fastHigh_r;        // Fast address high halves
  logic presentDis_r;                        // Software disable
  logic [DATA_W-1:0] busRdata_r;             // Read data
  logic [DATA_W-1:0] rdNxt;                  // Read mux
  phase_e phase_r;                           // Boot or running
  logic lowPowerPrev_r;                      // Edge detect of low power
  logic [SRC_NUM-1:0] wakeMask_r;            // Enables seen at entry
  logic wakeReq_r;                           // Wake to integration unit
  logic coreIrq_r;
  logic [1:0] coreLevel_r;
  logic [VEC_W-1:0] coreVector_r;
  logic coreFast_r;

  // ************************************
  // Address decode
  // ************************************
  // Base low bits are zero, so the offset is the low five bits
  logic hit;                                 // Address inside the block
  logic [OFF_W-1:0] off;                     // Register offset
  logic wrEn;                                // Write strobe
  logic rdEn;                                // Read strobe
  assign hit = busAddr[ADDR_W-1:OFF_W] == BASE_ADDR[ADDR_W-1:OFF_W];
  assign off = busAddr[OFF_W-1:0];
  assign wrEn = ce && busSel && busWr && hit;
  assign rdEn = ce && busSel && !busWr;

  // ************************************
  // Register writes
  // ************************************
  // Priority registers; reserved bits of register 0 never store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < PRIO_REGS; i++) begin
        prioReg_r[i] <= REG_RESET;
      end
    end else if (wrEn && off <= OFF_PRIO6) begin
      if (off == OFF_PRIO0) begin
        prioReg_r[0] <= busWdata & PRIO0_WMASK;
      end else begin
        prioReg_r[off[2:0]] <= busWdata;
      end
    end
  end

  // Vector base, fast channels and control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vba_r <= VBA_RESET;
      fastMatch_r <= '0;
      fastLow_r <= '0;
      fastHigh_r <= '0;
      presentDis_r <= 1'b0;
    end else if (wrEn) begin
      case (off)
        OFF_VBA: vba_r <= busWdata;
        OFF_FM0: fastMatch_r[0] <= busWdata;
        OFF_FVL0: fastLow_r[0] <= busWdata;
        OFF_FVH0: fastHigh_r[0] <= busWdata;
        OFF_FM1: fastMatch_r[1] <= busWdata;
        OFF_FVL1: fastLow_r[1] <= busWdata;
        OFF_FVH1: fastHigh_r[1] <= busWdata;
        OFF_CTRL: presentDis_r <= busWdata[CTRL_DIS_BIT];
        // Read-only and unmapped offsets ignore writes
        default: ;
      endcase
    end
  end

  // ************************************
  // Source configuration
  // ************************************
  logic [SRC_NUM-1:0] srcEn;                 // Source enabled
  logic [1:0] srcLvl [SRC_NUM];              // Source level

  // Map every source onto a fixed level or a priority field
  always_comb begin
    int f;
    int pos;
    logic [2:0] cfg;
    f = 0;
    pos = 0;
    cfg = '0;
    for (int s = 0; s < SRC_NUM; s++) begin
      if (s < FIXED_NUM) begin
        cfg = {1'b1, FIXED_LVL};
      end else if (s < FIXED_NUM + DBG_FIELDS) begin
        // Fields 0 and 1 sit above the reserved pair
        f = s - FIXED_NUM;
        pos = (f < 2) ? 14 - 2 * f : 12 - 2 * f;
        cfg = decodeField(prioReg_r[0][pos+:2], 1'b1);
      end else begin
        f = s - FIXED_NUM - DBG_FIELDS;
        pos = 2 * (f % FIELDS_PER_REG);
        cfg = decodeField(prioReg_r[1 + f / FIELDS_PER_REG][pos+:2], 1'b0);
      end
      srcEn[s] = cfg[2];
      srcLvl[s] = cfg[1:0];
    end
  end

  // ************************************
  // Level arbitration
  // ************************************
  logic [SRC_NUM-1:0] active;                // Enabled and requesting
  logic [SRC_NUM-1:0] levelReq [LVL_NUM];    // Requests per level
  logic [LVL_NUM-1:0] levelAny;              // Level has a request
  logic [NUM_W-1:0] levelNum [LVL_NUM];      // Winner per level
  assign active = irqIn & srcEn;

  // One encoder per level
  for (genvar l = 0; l < LVL_NUM; l++) begin : g_level
    always_comb begin
      for (int s = 0; s < SRC_NUM; s++) begin
        levelReq[l][s] = active[s] && srcLvl[s] == 2'(l);
      end
    end
    irq_level_encoder #(
      .WIDTH(SRC_NUM)
    ) u_enc (
      .req(levelReq[l]),
      .any(levelAny[l]),
      .idx(levelNum[l])
    );
  end

  logic topAny;                              // Some level requests
  logic [1:0] topLvl;                        // Highest requesting level
  logic [NUM_W-1:0] topNum;                  // Its winning number

  // Highest level first, then lowest number inside it
  always_comb begin
    topAny = 1'b0;
    topLvl = 2'h0;
    topNum = '0;
    for (int l = 0; l < LVL_NUM; l++) begin
      if (levelAny[l]) begin
        topAny = 1'b1;
        topLvl = 2'(l);
        topNum = levelNum[l];
      end
    end
  end

  // ************************************
  // Fast match
  // ************************************
  // Channel 0 wins if both channels hold the same number
  logic [1:0] fastHit;                       // Per channel match
  logic fastAny;
  for (genvar c = 0; c < 2; c++) begin : g_fast
    assign fastHit[c] = topAny && topLvl == FAST_LVL
                        && fastMatch_r[c][NUM_W-1:0] == topNum;
  end
  assign fastAny = |fastHit;

  // ************************************
  // Core presentation
  // ************************************
  logic present;                             // Request shown to core
  logic [VEC_W-1:0] vecNxt;
  assign present = topAny && !presentDis_r;

  // Address choice: fast channel or base joined with number
  always_comb begin
    if (fastHit[0]) begin
      vecNxt = {fastHigh_r[0], fastLow_r[0]};
    end else if (fastHit[1]) begin
      vecNxt = {fastHigh_r[1], fastLow_r[1]};
    end else begin
      vecNxt = {{(VEC_W - DATA_W - NUM_W){1'b0}}, vba_r, topNum};
    end
  end

  // Boot phase holds the initial fetch address for one enabled cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r <= PH_BOOT;
    end else if (ce) begin
      case (phase_r)
        PH_BOOT: phase_r <= PH_RUN;
        PH_RUN: phase_r <= PH_RUN;
        default: phase_r <= PH_BOOT;
      endcase
    end
  end

  // Outputs to the core, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coreIrq_r <= 1'b0;
      coreLevel_r <= CODE_NONE;
      coreVector_r <= RESET_VEC;
      coreFast_r <= 1'b0;
    end else if (ce) begin
      if (phase_r == PH_BOOT) begin
        coreIrq_r <= 1'b0;
        coreLevel_r <= CODE_NONE;
        coreVector_r <= RESET_VEC;
        coreFast_r <= 1'b0;
      end else if (present) begin
        coreIrq_r <= 1'b1;
        coreLevel_r <= levelToCode(topLvl);
        coreVector_r <= vecNxt;
        coreFast_r <= fastAny;
      end else begin
        // Core masks levels itself; none pending shows code zero
        coreIrq_r <= 1'b0;
        coreLevel_r <= CODE_NONE;
        coreVector_r <= vecNxt;
        coreFast_r <= 1'b0;
      end
    end
  end

  // ************************************
  // Low-power wake
  // ************************************
  // Enables are frozen on entry; later enables cannot wake
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lowPowerPrev_r <= 1'b0;
      wakeMask_r <= '0;
      wakeReq_r <= 1'b0;
    end else if (ce) begin
      lowPowerPrev_r <= lowPower;
      if (lowPower && !lowPowerPrev_r) begin
        wakeMask_r <= srcEn;
      end
      wakeReq_r <= lowPower && lowPowerPrev_r
                   && |(active & wakeMask_r);
    end
  end

  // ************************************
  // Register reads
  // ************************************
  // Unmapped offsets and foreign addresses read as zero
  always_comb begin
    rdNxt = '0;
    if (hit) begin
      case (off)
        OFF_VBA: rdNxt = vba_r;
        OFF_FM0: rdNxt = fastMatch_r[0];
        OFF_FVL0: rdNxt = fastLow_r[0];
        OFF_FVH0: rdNxt = fastHigh_r[0];
        OFF_FM1: rdNxt = fastMatch_r[1];
        OFF_FVL1: rdNxt = fastLow_r[1];
        OFF_FVH1: rdNxt = fastHigh_r[1];
        OFF_CTRL: begin
          rdNxt[CTRL_CODE_LSB+:2] = coreLevel_r;
          rdNxt[CTRL_REQ_BIT] = coreIrq_r;
          rdNxt[CTRL_NUM_LSB+:NUM_W] = topNum;
          rdNxt[CTRL_DIS_BIT] = presentDis_r;
        end
        default: begin
          if (off <= OFF_PRIO6) begin
            rdNxt = prioReg_r[off[2:0]];
          end else if (off >= OFF_PEND0 && off <= OFF_PEND3) begin
            rdNxt = active[DATA_W * (off - OFF_PEND0)+:DATA_W];
          end
        end
      endcase
    end
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busRdata_r <= '0;
    end else if (rdEn) begin
      busRdata_r <= rdNxt;
    end
  end

  assign busRdata = busRdata_r;
  assign wakeReq = wakeReq_r;
  assign coreIrq = coreIrq_r;
  assign coreLevel = coreLevel_r;
  assign coreVector = coreVector_r;
  assign coreFast = coreFast_r;
  assign bootDrive = phase_r == PH_BOOT;

  // ************************************
  // Assertions
  // ************************************
  logic higherAny;                           // Request above top level
  always_comb begin
    higherAny = 1'b0;
    for (int l = 0; l < LVL_NUM; l++) begin
      if (topAny && 2'(l) > topLvl && levelAny[l]) higherAny = 1'b1;
    end
  end

  a_top_level: assert property (@(posedge ref_clk) disable iff (rst) !higherAny)
    else $error("Lower level chosen over active higher level");
  a_lowest_wins: assert property (@(posedge ref_clk) disable iff (rst)
    topAny |-> levelReq[topLvl][topNum]
    && !(|(levelReq[topLvl] & ((64'h1 << topNum) - 64'h1))))
    else $error("Winner is not the lowest active number");
  a_code_level0: assert property (@(posedge ref_clk) disable iff (rst)
    ce && phase_r == PH_RUN && present && topLvl == 2'h0 |=> coreLevel == CODE_L0 && coreIrq)
    else $error("Level 0 request not shown as code 01");
  a_code_level3: assert property (@(posedge ref_clk) disable iff (rst)
    ce && phase_r == PH_RUN && present && topLvl == 2'h3 |=> coreLevel == CODE_L23)
    else $error("Level 3 request not shown as code 11");
  a_idle_code: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !topAny |=> !coreIrq && coreLevel == CODE_NONE)
    else $error("Request shown with nothing pending");
  a_normal_vector: assert property (@(posedge ref_clk) disable iff (rst)
    ce && phase_r == PH_RUN && !fastAny
    |=> coreVector == {{(VEC_W - DATA_W - NUM_W){1'b0}}, $past(vba_r), $past(topNum)})
    else $error("Normal vector is not base joined with number");
  a_fast_vector: assert property (@(posedge ref_clk) disable iff (rst)
    ce && phase_r == PH_RUN && present && fastHit[0]
    |=> coreFast && coreVector == {$past(fastHigh_r[0]), $past(fastLow_r[0])})
    else $error("Fast channel 0 address not presented");
  a_fast_level: assert property (@(posedge ref_clk) disable iff (rst)
    ce && topLvl != FAST_LVL |=> !coreFast)
    else $error("Fast flag outside level 2");
  a_wake_enabled: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !(|(active & wakeMask_r)) |=> !wakeReq)
    else $error("Wake from a source not enabled at entry");
  a_boot_vector: assert property (@(posedge ref_clk) disable iff (rst)
    bootDrive |-> coreVector == RESET_VEC && !coreIrq)
    else $error("Initial fetch address not driven after reset");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    rdEn && busAddr == BASE_ADDR |=> busRdata[11:10] == 2'h0)
    else $error("Reserved bits of priority register 0 read nonzero");

endmodule // irq_arbiter_unit

// file: test/core_irq_model.sv
// Behavioural model of the processor core that takes the presented request
`timescale 1ns/1ps
module core_irq_model
  import irq_arbiter_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Presented request from the arbiter
  input wire logic coreIrq,
  input wire logic [1:0] coreLevel,
  input wire logic [VEC_W-1:0] coreVector,
  input wire logic coreFast,
  // Core state set by the bench
  input wire logic [1:0] maskBits,
  input wire logic jumpAtVector,
  // Observed core behaviour
  output logic accepted,
  output logic fastEntry,
  output logic [VEC_W-1:0] fetchAddr
);
  // ************************************
  // Acceptance
  // ************************************
  logic okNow; // Request passes the status mask
  // Mask 11 lets code 11 through, since that code stands for levels 2 and 3 alike
  assign okNow = coreIrq && (coreLevel > maskBits || (maskBits == 2'h3 && coreLevel == 2'h3));

  // Registered like a real core: it acts one edge after it sees the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accepted <= 1'b0;
      fastEntry <= 1'b0;
      fetchAddr <= '0;
    end else begin
      accepted <= okNow;
      fastEntry <= okNow && coreFast && !jumpAtVector;
      fetchAddr <= coreVector;
    end
  end
endmodule // core_irq_model

// file: test/prioritized_irq_vector_controller_tb.sv
// Self-checking bench for the interrupt arbiter with a core model
`timescale 1ns/1ps
module prioritized_irq_vector_controller_tb;
  import irq_arbiter_pkg::*;
  // ************************************
  // Signals
  // ************************************
  localparam logic [VEC_W-1:0] BOOT_VEC = 32'h00000abc; // Initial fetch address, arbitrary
  localparam logic [DATA_W-1:0] BASE_RST = 16'h0000; // Vector base after reset
  logic ref_clk = 1'b0;
  logic rst, ce, busSel, busWr, lowPower, jumpAtVector;
  logic [SRC_NUM-1:0] irqIn;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busWdata, busRdata, rd, vector_table_base;
  logic wakeReq, coreIrq, coreFast, bootDrive, accepted, fastEntry;
  logic [1:0] coreLevel, maskBits;
  logic [VEC_W-1:0] coreVector, fetchAddr;
  logic [DATA_W-1:0] shadow [0:PRIO_REGS-1]; // Bench copy of the priority registers
  int num_errors, comparisons;

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // ************************************
  // Design and core model
  // ************************************
  irq_arbiter_unit #(.RESET_VEC(BOOT_VEC), .VBA_RESET(BASE_RST)) DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .irqIn(irqIn), .busSel(busSel), .busWr(busWr),
    .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .lowPower(lowPower),
    .wakeReq(wakeReq), .coreIrq(coreIrq), .coreLevel(coreLevel), .coreVector(coreVector),
    .coreFast(coreFast), .bootDrive(bootDrive));
  core_irq_model core (
    .ref_clk(ref_clk), .rst(rst), .coreIrq(coreIrq), .coreLevel(coreLevel), .coreVector(coreVector),
    .coreFast(coreFast), .maskBits(maskBits), .jumpAtVector(jumpAtVector), .accepted(accepted),
    .fastEntry(fastEntry), .fetchAddr(fetchAddr));

  // ************************************
  // Tasks
  // ************************************
  // Inputs always move 5 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) fail($sformatf("%s got %b", what, got));
  endtask

  // Vector and fast flag only matter while a request is presented
  task automatic chk_core(input logic irq, input logic [1:0] lvl, input logic [31:0] vec, input logic fast);
    comparisons++;
    if (coreIrq !== irq || coreLevel !== lvl || (irq && (coreVector !== vec || coreFast !== fast)))
      fail($sformatf("core irq %b lvl %b vec %h fast %b", coreIrq, coreLevel, coreVector, coreFast));
  endtask

  function automatic logic [23:0] ra(input logic [4:0] off);
    return BASE_ADDR | {19'h0, off};
  endfunction

  function automatic logic [31:0] nvec(input logic [5:0] n);
    return {10'h0, vector_table_base, n};
  endfunction

  // One strobe cycle, then an idle cycle so strobes never meet in one time step
  task automatic bus_wr(input logic [23:0] a, input logic [15:0] d);
    busSel = 1'b1; busWr = 1'b1; busAddr = a; busWdata = d;
    tick();
    busSel = 1'b0; busWr = 1'b0;
    tick();
  endtask

  task automatic bus_rd(input logic [23:0] a, output logic [15:0] d);
    busSel = 1'b1; busWr = 1'b0; busAddr = a;
    tick();
    d = busRdata;
    busSel = 1'b0;
    tick();
  endtask

  task automatic reg_chk(input logic [4:0] off, input logic [15:0] exp, input string what);
    bus_rd(ra(off), rd);
    chk16(rd, exp, what);
  endtask

  // Place a two-bit priority code in the field of one source
  task automatic set_src(input int s, input logic [1:0] code);
    int r, b;
    if (s < 16) begin
      r = 0;
      b = (s == 9) ? 14 : (s == 10) ? 12 : (15 - s) * 2;
    end else begin
      r = 1 + (s - 16) / 8;
      b = 2 * ((s - 16) % 8);
    end
    shadow[r][b +: 2] = code;
    bus_wr(ra(r[4:0]), shadow[r]);
  endtask

  task automatic clear_prio;
    for (int r = 0; r < PRIO_REGS; r++) begin
      shadow[r] = 16'h0000;
      bus_wr(ra(r[4:0]), 16'h0000);
    end
  endtask

  // Bounded wait; running out counts as a mismatch
  task automatic wait_wake(input int bound);
    int i;
    for (i = 0; i < bound && wakeReq !== 1'b1; i++) tick();
    chk_flag(wakeReq, 1'b1, "wake request");
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    rst = 1'b1; ce = 1'b1; irqIn = '0; busSel = 1'b0; busWr = 1'b0; busAddr = '0; busWdata = '0;
    lowPower = 1'b0; maskBits = 2'h0; jumpAtVector = 1'b0; num_errors = 0; comparisons = 0;
    vector_table_base = 16'h1234;
    for (int r = 0; r < PRIO_REGS; r++) shadow[r] = 16'h0000;
    tick(8);
    chk_flag(bootDrive, 1'b1, "boot drive in reset");
    chk16(coreVector[15:0], BOOT_VEC[15:0], "boot vector");
    rst = 1'b0;
    tick();
    chk_flag(bootDrive, 1'b0, "boot drive after release");
    // Reset values and access kinds
    for (int r = 0; r < PRIO_REGS; r++) reg_chk(r[4:0], 16'h0000, "priority reset");
    reg_chk(OFF_VBA, BASE_RST, "base reset");
    bus_wr(ra(OFF_PRIO0), 16'hffff);
    reg_chk(OFF_PRIO0, 16'hf3ff, "reserved bits stored");
    for (int o = 1; o < 14; o++) begin
      bus_wr(ra(o[4:0]), 16'h5a00 | o[15:0]);
      reg_chk(o[4:0], 16'h5a00 | o[15:0], "register readback");
    end
    clear_prio();
    bus_wr(24'h00f100, 16'hffff);
    reg_chk(OFF_PRIO0, 16'h0000, "write outside block");
    bus_wr(ra(5'h12), 16'hffff);
    reg_chk(5'h12, 16'h0000, "unmapped offset");
    bus_rd(24'h00f0c7, rd);
    chk16(rd, 16'h0000, "read outside block");
    bus_wr(ra(OFF_PEND0), 16'hffff);
    reg_chk(OFF_PEND0, 16'h0000, "pending written");
    bus_wr(ra(OFF_VBA), vector_table_base);
    // Every peripheral code on one source; code n gives level n-1
    irqIn[20] = 1'b1;
    for (int c = 0; c < 4; c++) begin
      set_src(20, c[1:0]);
      tick();
      chk_core(c != 0, c[1:0], nvec(6'd20), 1'b0);
    end
    reg_chk(5'h0f, 16'h0010, "pending sources");
    // Order within a level, then across levels
    set_src(20, 2'h2);
    set_src(17, 2'h2);
    irqIn[17] = 1'b1;
    tick();
    chk_core(1'b1, 2'h2, nvec(6'd17), 1'b0);
    set_src(40, 2'h3);
    irqIn[40] = 1'b1;
    tick();
    chk_core(1'b1, 2'h3, nvec(6'd40), 1'b0);
    irqIn[8] = 1'b1;
    tick();
    chk_core(1'b1, 2'h3, nvec(6'd8), 1'b0);
    irqIn[0] = 1'b1;
    tick();
    chk_core(1'b1, 2'h3, nvec(6'd0), 1'b0);
    clear_prio();
    irqIn = '0;
    irqIn[63] = 1'b1;
    set_src(63, 2'h1);
    chk_core(1'b1, 2'h1, nvec(6'd63), 1'b0);
    irqIn[62] = 1'b1;
    set_src(62, 2'h1);
    chk_core(1'b1, 2'h1, nvec(6'd62), 1'b0);
    clear_prio();
    // Every field of priority register 0; code n gives level n
    for (int s = 9; s < 16; s++) begin
      irqIn = '0;
      irqIn[s] = 1'b1;
      set_src(s, 2'((s % 3) + 1));
      tick();
      chk_core(1'b1, (s % 3 == 0) ? 2'h2 : 2'h3, nvec(6'(s)), 1'b0);
      set_src(s, 2'h0);
    end
    // Fast channels programmed by software
    irqIn = '0;
    bus_wr(ra(OFF_FM0), 16'd40);
    bus_wr(ra(OFF_FVL0), 16'hbeef);
    bus_wr(ra(OFF_FVH0), 16'h0012);
    bus_wr(ra(OFF_FM1), 16'd41);
    bus_wr(ra(OFF_FVL1), 16'hcafe);
    bus_wr(ra(OFF_FVH1), 16'h0034);
    irqIn[40] = 1'b1;
    set_src(40, 2'h3);
    chk_core(1'b1, 2'h3, 32'h0012beef, 1'b1);
    set_src(40, 2'h2);
    chk_core(1'b1, 2'h2, nvec(6'd40), 1'b0);
    set_src(40, 2'h0);
    irqIn[41] = 1'b1;
    set_src(41, 2'h3);
    chk_core(1'b1, 2'h3, 32'h0034cafe, 1'b1);
    // Core side: fast entry unless the vector holds a subroutine jump
    maskBits = 2'h3;
    tick();
    chk_flag(fastEntry, 1'b1, "fast entry");
    jumpAtVector = 1'b1;
    tick();
    chk_flag(fastEntry, 1'b0, "jump at vector");
    set_src(41, 2'h2);
    maskBits = 2'h1;
    tick();
    chk_flag(accepted, 1'b1, "level 1 under mask 01");
    maskBits = 2'h2;
    tick();
    chk_flag(accepted, 1'b0, "level 1 under mask 10");
    reg_chk(OFF_CTRL, {2'h2, 1'b1, 6'd41, 7'h00}, "control status");
    bus_wr(ra(OFF_CTRL), 16'h0020);
    chk_core(1'b0, CODE_NONE, '0, 1'b0);
    bus_wr(ra(OFF_CTRL), 16'h0000);
    // Wake only for sources enabled before low power
    clear_prio();
    irqIn = '0;
    set_src(20, 2'h1);
    lowPower = 1'b1;
    tick(2);
    irqIn[21] = 1'b1;
    set_src(21, 2'h1);
    tick(2);
    chk_flag(wakeReq, 1'b0, "wake from late source");
    irqIn[20] = 1'b1;
    wait_wake(4);
    // Clock enable low freezes the wake request even after the source drops
    ce = 1'b0;
    irqIn = '0;
    tick(2);
    chk_flag(wakeReq, 1'b1, "wake frozen while disabled");
    ce = 1'b1;
    tick();
    chk_flag(wakeReq, 1'b0, "wake drops with source");
    lowPower = 1'b0;
    wrap_up();
  end
endmodule // prioritized_irq_vector_controller_tb
